// File: cpps_top.sv
/*
  cache policy resolver and self-modifying code detector.
  assumes core fetch and load/store strobes are synchronous to CORE_CLK.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpps_params.svh"
module cpps_top
  import cpps_pkg::*;
(
  input  wire logic                    CORE_CLK,
  input  wire logic                    RESET,
  input  wire logic                    GLOBAL_CACHE_DISABLE_FLAG,
  input  wire logic                    NOT_WRITE_THROUGH_FLAG,
  input  wire logic                    EXT_CACHE_DISABLE,
  input  wire logic                    EXT_FORCE_WT,
  input  wire logic [2:0]              RANGE_MEM_TYPE,
  input  wire logic                    RANGE_HIT,
  input  wire cpps_page_t              PAGE_FLAGS,
  input  wire logic                    LINE_WT_SELECT,
  input  wire logic [7:0]              MISC_FEATURE_ENABLE,
  input  wire logic                    ACC_IS_FETCH,
  input  wire logic                    ACC_MISS,
  input  wire cpps_req_t               FETCH_PUSH,
  input  wire logic                    FETCH_POP,
  input  wire cpps_req_t               STORE_REQ,
  input  wire logic                    SERIALIZE,
  output var logic                     L1I_ALLOC,
  output var logic                     L1D_ALLOC,
  output var logic                     L2_ALLOC,
  output var logic                     L3_ALLOC,
  output var logic                     L3_ENABLED,
  output var logic                     WRITE_BACK,
  output var logic                     WRITE_THROUGH,
  output var logic                     UNCACHED,
  output var logic                     PQ_FLUSH_OUT,
  output var logic                     SMC_HIT,
  output var logic [`CPPS_PQ_IDX_W:0]  PQ_COUNT
);
  logic                                page_cd;
  logic                                page_wt;
  logic                                glob_cd;
  logic                                glob_wt;
  logic                                range_cd;
  logic                                range_wt;
  logic                                no_cache;
  logic                                use_wt;
  logic                                l3_on;
  logic                                alloc_ok;
  logic                                hit;
  logic [`CPPS_PQ_IDX_W:0]             count;
  logic                                flush_req;
  logic                                pol_wb;
  logic                                pol_wt;
  logic                                pol_uc;
  logic                                flush_on;
  logic                                alloc_l1i;
  logic                                alloc_l1d;
  logic                                alloc_l2;
  logic                                alloc_l3;
  cpps_pol_t                           pol_next;
  cpps_pq_st_t                         st_reg;
  cpps_pq_st_t                         st_next;
  // page flags combine across base register, directory and table
  assign page_cd  = PAGE_FLAGS.base_pcd | PAGE_FLAGS.dir_pcd | PAGE_FLAGS.tbl_pcd;
  assign page_wt  = PAGE_FLAGS.base_pwt | PAGE_FLAGS.dir_pwt | PAGE_FLAGS.tbl_pwt;
  // global flags: 00 writeback, cache disable stops allocation
  assign glob_cd  = GLOBAL_CACHE_DISABLE_FLAG;
  assign glob_wt  = NOT_WRITE_THROUGH_FLAG == 1'b0 ? 1'b0 : 1'b0;
  // range type combines with global choice; any uncached source wins, then any write-through source
  assign range_cd = RANGE_HIT & (RANGE_MEM_TYPE == `CPPS_MT_UC || RANGE_MEM_TYPE == `CPPS_MT_WC);
  assign range_wt = RANGE_HIT & (RANGE_MEM_TYPE == `CPPS_MT_WT || RANGE_MEM_TYPE == `CPPS_MT_WP);
  assign no_cache = glob_cd | range_cd | page_cd | EXT_CACHE_DISABLE;
  assign use_wt   = glob_wt | range_wt | page_wt | EXT_FORCE_WT | LINE_WT_SELECT;
  assign pol_next = no_cache ? POL_UC : (use_wt ? POL_WT : POL_WB);
  assign l3_on    = ~MISC_FEATURE_ENABLE[`CPPS_L3_DIS_BIT];
  // valid lines keep serving hits; only misses allocate and only when cacheable
  assign alloc_ok = ACC_MISS & ~no_cache;
  assign flush_req = hit | SERIALIZE;
  // policy decode feeding the output flops
  assign pol_wb    = (pol_next == POL_WB);
  assign pol_wt    = (pol_next == POL_WT);
  assign pol_uc    = (pol_next == POL_UC);
  assign flush_on  = (st_next == PQ_FLUSH);
  // per-level allocation strobes
  assign alloc_l1i = alloc_ok & ACC_IS_FETCH;
  assign alloc_l1d = alloc_ok & ~ACC_IS_FETCH;
  assign alloc_l2  = alloc_ok;
  assign alloc_l3  = alloc_ok & l3_on;
  cpps_pq_snoop u_pq
  (
    .clk       (CORE_CLK),
    .rst       (RESET),
    .push      (FETCH_PUSH),
    .pop       (FETCH_POP),
    .store     (STORE_REQ),
    .serialize (SERIALIZE),
    .hit       (hit),
    .count     (count)
  );
  // flush state: one cycle in flush after each hit or serializing operation
  always_comb
  begin
    st_next = PQ_RUN;
    case (st_reg)
      PQ_RUN:
        st_next = flush_req ? PQ_FLUSH : PQ_RUN;
      PQ_FLUSH:
        st_next = flush_req ? PQ_FLUSH : PQ_RUN;
      default:
        st_next = PQ_RUN;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      st_reg <= PQ_RUN;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // policy outputs, uncached while in reset
  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      WRITE_BACK    <= 1'b0;
      WRITE_THROUGH <= 1'b0;
      UNCACHED      <= 1'b1;
    end
    else
    begin
      WRITE_BACK    <= pol_wb;
      WRITE_THROUGH <= pol_wt;
      UNCACHED      <= pol_uc;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      L1I_ALLOC <= 1'b0;
      L1D_ALLOC <= 1'b0;
    end
    else
    begin
      L1I_ALLOC <= alloc_l1i;
      L1D_ALLOC <= alloc_l1d;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      L2_ALLOC <= 1'b0;
    end
    else
    begin
      L2_ALLOC <= alloc_l2;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      L3_ALLOC <= 1'b0;
    end
    else
    begin
      L3_ALLOC <= alloc_l3;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      L3_ENABLED <= 1'b0;
    end
    else
    begin
      L3_ENABLED <= l3_on;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      SMC_HIT <= 1'b0;
    end
    else
    begin
      SMC_HIT <= hit;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PQ_FLUSH_OUT <= 1'b0;
    end
    else
    begin
      PQ_FLUSH_OUT <= flush_on;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      PQ_COUNT <= '0;
    end
    else
    begin
      PQ_COUNT <= count;
    end
  end
endmodule
`default_nettype wire

// File: cpps_params.svh
/*
  constants for the cache policy and prefetch snoop block.
  assumes it is included by the package and the design modules; no process here.
*/
`ifndef CPPS_PARAMS_SVH
`define CPPS_PARAMS_SVH
`define CPPS_ADDR_W 32
`define CPPS_PQ_DEPTH 4
`define CPPS_PQ_IDX_W 2
`define CPPS_L3_DIS_BIT 6
`define CPPS_MT_UC 3'h0
`define CPPS_MT_WC 3'h1
`define CPPS_MT_WT 3'h4
`define CPPS_MT_WP 3'h5
`define CPPS_MT_WB 3'h6
`define CPPS_LINE_MASK 32'hffffffe0
`endif

// File: cpps_pkg.sv
/*
  types for the cache policy and prefetch snoop block.
  assumes cpps_params.svh sits in the same folder.
*/
`default_nettype none
`include "cpps_params.svh"
package cpps_pkg;
  typedef enum logic [2:0] {
    POL_UC = 3'h1,
    POL_WT = 3'h2,
    POL_WB = 3'h4
  } cpps_pol_t;
  typedef struct packed {
    logic valid;
    logic [`CPPS_ADDR_W-1:0] lin_addr;
  } cpps_req_t;
  typedef struct packed {
    logic base_pcd;
    logic base_pwt;
    logic dir_pcd;
    logic dir_pwt;
    logic tbl_pcd;
    logic tbl_pwt;
  } cpps_page_t;
  typedef enum logic [1:0] {
    PQ_RUN   = 2'h1,
    PQ_FLUSH = 2'h2
  } cpps_pq_st_t;
endpackage
`default_nettype wire

// File: cpps_pq_snoop.sv
/*
  prefetch queue linear address tracker with store snoop.
  assumes fetch pushes and decode pops are single-cycle strobes from the core.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cpps_params.svh"
module cpps_pq_snoop
  import cpps_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire cpps_req_t               push,
  input  wire logic                    pop,
  input  wire cpps_req_t               store,
  input  wire logic                    serialize,
  output logic                         hit,
  output logic [`CPPS_PQ_IDX_W:0]      count
);
  logic [`CPPS_PQ_DEPTH-1:0]           vld_reg;
  logic [`CPPS_ADDR_W-1:0]             addr_reg [`CPPS_PQ_DEPTH];
  logic [`CPPS_PQ_DEPTH-1:0]           match;
  logic [`CPPS_PQ_IDX_W-1:0]           wr_reg;
  logic [`CPPS_PQ_IDX_W-1:0]           rd_reg;
  logic [`CPPS_PQ_IDX_W:0]             cnt_reg;
  logic                                flush;
  logic                                do_push;
  logic                                do_pop;
  genvar g;
  // linear address compare per entry
  generate
    for (g = 0; g < `CPPS_PQ_DEPTH; g = g + 1)
    begin : g_cmp
      assign match[g] = vld_reg[g] & store.valid & (addr_reg[g] == store.lin_addr);
    end
  endgenerate
  assign hit     = |match;
  assign flush   = hit | serialize;
  assign do_push = push.valid & (cnt_reg != (`CPPS_PQ_IDX_W+1)'(`CPPS_PQ_DEPTH)) & ~flush;
  assign do_pop  = pop & (cnt_reg != '0) & ~flush;
  assign count   = cnt_reg;
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      vld_reg <= '0;
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (flush)
    begin
      vld_reg <= '0;
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (do_push)
        vld_reg[wr_reg] <= 1'b1;
      if (do_pop)
        vld_reg[rd_reg] <= 1'b0;
      if (do_push)
        wr_reg <= wr_reg + 1'b1;
      if (do_pop)
        rd_reg <= rd_reg + 1'b1;
      cnt_reg <= cnt_reg + {{`CPPS_PQ_IDX_W{1'b0}}, do_push} - {{`CPPS_PQ_IDX_W{1'b0}}, do_pop};
    end
  end
  always_ff @(posedge clk)
  begin
    if (do_push)
      addr_reg[wr_reg] <= push.lin_addr;
  end
endmodule
`default_nettype wire

// File: cpps_props.sv
/* cpps_props: assertions on the cpps_top ports.
   assumes a bind onto cpps_top; one clock, async reset high. */
`timescale 1ns/1ps
`default_nettype none
`include "cpps_params.svh"
module cpps_props
  import cpps_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RESET,
  input wire logic       GLOBAL_CACHE_DISABLE_FLAG,
  input wire logic       EXT_CACHE_DISABLE,
  input wire logic       EXT_FORCE_WT,
  input wire logic [2:0] RANGE_MEM_TYPE,
  input wire logic       RANGE_HIT,
  input wire cpps_page_t PAGE_FLAGS,
  input wire logic       LINE_WT_SELECT,
  input wire logic [7:0] MISC_FEATURE_ENABLE,
  input wire logic       SERIALIZE,
  input wire logic       L2_ALLOC,
  input wire logic       L3_ALLOC,
  input wire logic       L3_ENABLED,
  input wire logic       WRITE_BACK,
  input wire logic       UNCACHED,
  input wire logic       PQ_FLUSH_OUT,
  input wire logic       SMC_HIT
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  property p_wb; !GLOBAL_CACHE_DISABLE_FLAG && !EXT_CACHE_DISABLE && !EXT_FORCE_WT && !RANGE_HIT
    && PAGE_FLAGS == '0 && !LINE_WT_SELECT |=> WRITE_BACK; endproperty
  a_wb: assert property (p_wb) else $error("writeback missing");
  property p_line; LINE_WT_SELECT |=> !WRITE_BACK; endproperty
  a_line: assert property (p_line) else $error("line write-through ignored");
  property p_ext; EXT_CACHE_DISABLE |=> UNCACHED && !WRITE_BACK; endproperty
  a_ext: assert property (p_ext) else $error("external disable ignored");
  property p_extwt; EXT_FORCE_WT |=> !WRITE_BACK; endproperty
  a_extwt: assert property (p_extwt) else $error("external write-through ignored");
  property p_rng; RANGE_HIT && RANGE_MEM_TYPE == `CPPS_MT_UC |=> UNCACHED; endproperty
  a_rng: assert property (p_rng) else $error("range type ignored");
  property p_pcd; PAGE_FLAGS.base_pcd || PAGE_FLAGS.dir_pcd || PAGE_FLAGS.tbl_pcd |=> UNCACHED; endproperty
  a_pcd: assert property (p_pcd) else $error("page disable ignored");
  property p_hit; SMC_HIT |-> PQ_FLUSH_OUT; endproperty
  a_hit: assert property (p_hit) else $error("hit without flush");
  property p_ser; SERIALIZE |=> PQ_FLUSH_OUT; endproperty
  a_ser: assert property (p_ser) else $error("serialize without flush");
  property p_l3; 1'b1 |=> L3_ENABLED == !$past(MISC_FEATURE_ENABLE[`CPPS_L3_DIS_BIT]); endproperty
  a_l3: assert property (p_l3) else $error("level-3 enable wrong");
  property p_noal; GLOBAL_CACHE_DISABLE_FLAG || EXT_CACHE_DISABLE |=> !L2_ALLOC && !L3_ALLOC; endproperty
  a_noal: assert property (p_noal) else $error("allocation while disabled");
  c_hit: cover property (SMC_HIT);
  c_l3: cover property (L3_ALLOC);
  c_wb: cover property (WRITE_BACK && L2_ALLOC);
endmodule
bind cpps_top cpps_props cpps_props_i
(
  .CORE_CLK                  (CORE_CLK),
  .RESET                     (RESET),
  .GLOBAL_CACHE_DISABLE_FLAG (GLOBAL_CACHE_DISABLE_FLAG),
  .EXT_CACHE_DISABLE         (EXT_CACHE_DISABLE),
  .EXT_FORCE_WT              (EXT_FORCE_WT),
  .RANGE_MEM_TYPE            (RANGE_MEM_TYPE),
  .RANGE_HIT                 (RANGE_HIT),
  .PAGE_FLAGS                (PAGE_FLAGS),
  .LINE_WT_SELECT            (LINE_WT_SELECT),
  .MISC_FEATURE_ENABLE       (MISC_FEATURE_ENABLE),
  .SERIALIZE                 (SERIALIZE),
  .L2_ALLOC                  (L2_ALLOC),
  .L3_ALLOC                  (L3_ALLOC),
  .L3_ENABLED                (L3_ENABLED),
  .WRITE_BACK                (WRITE_BACK),
  .UNCACHED                  (UNCACHED),
  .PQ_FLUSH_OUT              (PQ_FLUSH_OUT),
  .SMC_HIT                   (SMC_HIT)
);
`default_nettype wire

// File: cpps_core_model.sv
/* cpps_core_model: core fetch and store side, random traffic.
   assumes the bench gives clock, reset and a stall request. */
`timescale 1ns/1ps
`default_nettype none
module cpps_core_model
  import cpps_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic stall,
  output cpps_req_t push = '0,
  output logic      pop = 1'b0,
  output cpps_req_t store = '0,
  output logic      serialize = 1'b0
);
  logic pv;
  logic sv;
  always @(negedge clk)
  begin
    pv = !rst && !stall && $urandom % 2 == 0;
    sv = !rst && $urandom % 8 == 0;
    push <= '{pv, pv ? 32'h1000 + 32'($urandom % 6) * 4 : ~push.lin_addr};
    store <= '{sv, sv ? 32'h1000 + 32'($urandom % 8) * 4 : ~store.lin_addr};
    pop <= !rst && $urandom % 3 == 0;
    serialize <= !rst && $urandom % 16 == 0;
  end
endmodule
`default_nettype wire

// File: cpps_top_test.sv
/* cpps_top_test: random bench with a queue model of the snoop.
   assumes cpps_core_model drives the fetch and store side. */
`timescale 1ns/1ps
`default_nettype none
`include "cpps_params.svh"
module cpps_top_test
  import cpps_pkg::*;
;
  logic CORE_CLK = 1'b0, RESET = 1'b1, GLOBAL_CACHE_DISABLE_FLAG = 1'b0, NOT_WRITE_THROUGH_FLAG = 1'b0;
  logic EXT_CACHE_DISABLE = 1'b0, EXT_FORCE_WT = 1'b0, RANGE_HIT = 1'b0, LINE_WT_SELECT = 1'b0, stall = 1'b0;
  logic ACC_IS_FETCH = 1'b0, ACC_MISS = 1'b0, FETCH_POP, SERIALIZE, L3_ENABLED, PQ_FLUSH_OUT, SMC_HIT;
  logic L1I_ALLOC, L1D_ALLOC, L2_ALLOC, L3_ALLOC, WRITE_BACK, WRITE_THROUGH, UNCACHED, uc, wt, e_hit, e_fl, e_l3;
  logic [2:0] RANGE_MEM_TYPE = 3'h0, PQ_COUNT, e_pol, e_cnt;
  logic [2:0] mt [5] = '{`CPPS_MT_UC, `CPPS_MT_WC, `CPPS_MT_WT, `CPPS_MT_WP, `CPPS_MT_WB};
  logic [7:0] MISC_FEATURE_ENABLE = 8'h00;
  logic [3:0] e_al;
  logic [31:0] q [$];
  cpps_page_t PAGE_FLAGS = '0;
  cpps_req_t FETCH_PUSH, STORE_REQ;
  int miscompares = 0, check_count = 0, cyc = 0, n = 0;
  cpps_top cpps_top_i (.*);
  cpps_core_model cpps_core_model_i (.clk(CORE_CLK), .rst(RESET), .stall(stall), .push(FETCH_PUSH),
    .pop(FETCH_POP), .store(STORE_REQ), .serialize(SERIALIZE));
  always #4 CORE_CLK = ~CORE_CLK;
  task automatic conclude;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [3:0] g, input logic [3:0] e, input string m);
    check_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("BAD %0t %s got %h want %h", $time, m, g, e);
    end
  endtask
  always @(posedge CORE_CLK)
  begin
    uc = GLOBAL_CACHE_DISABLE_FLAG | EXT_CACHE_DISABLE | PAGE_FLAGS.base_pcd | PAGE_FLAGS.dir_pcd
      | PAGE_FLAGS.tbl_pcd | (RANGE_HIT && RANGE_MEM_TYPE inside {`CPPS_MT_UC, `CPPS_MT_WC});
    wt = EXT_FORCE_WT | LINE_WT_SELECT | PAGE_FLAGS.base_pwt | PAGE_FLAGS.dir_pwt | PAGE_FLAGS.tbl_pwt
      | (RANGE_HIT && RANGE_MEM_TYPE inside {`CPPS_MT_WT, `CPPS_MT_WP});
    e_pol = RESET || uc ? 3'h1 : wt ? 3'h2 : 3'h4;
    e_al = ACC_MISS && !uc && !RESET ? {ACC_IS_FETCH, !ACC_IS_FETCH, 1'b1, !MISC_FEATURE_ENABLE[6]} : 4'h0;
    e_l3 = !RESET && !MISC_FEATURE_ENABLE[6];
    e_cnt = RESET ? 3'h0 : 3'(q.size());
    e_hit = !RESET && STORE_REQ.valid && (STORE_REQ.lin_addr inside {q});
    e_fl = e_hit || (!RESET && SERIALIZE);
    n = q.size();
    if (RESET || e_fl)
      q = {};
    else
    begin
      if (FETCH_POP && n > 0)
        void'(q.pop_front());
      if (FETCH_PUSH.valid && n < `CPPS_PQ_DEPTH)
        q.push_back(FETCH_PUSH.lin_addr);
    end
  end
  always @(negedge CORE_CLK)
  begin
    if (!RESET)
    begin
      chk({1'b0, WRITE_BACK, WRITE_THROUGH, UNCACHED}, {1'b0, e_pol}, "policy");
      chk({L1I_ALLOC, L1D_ALLOC, L2_ALLOC, L3_ALLOC}, e_al, "alloc");
      chk({3'h0, L3_ENABLED}, {3'h0, e_l3}, "level-3 enable");
      chk({2'h0, SMC_HIT, PQ_FLUSH_OUT}, {2'h0, e_hit, e_fl}, "snoop");
      chk({1'b0, PQ_COUNT}, {1'b0, e_cnt}, "count");
    end
    if (++cyc > 7000)
    begin
      miscompares++;
      conclude();
    end
  end
  task automatic run(input logic l3d, input logic slow);
    stall = slow;
    ACC_MISS = 1'b0;
    MISC_FEATURE_ENABLE[6] = l3d;
    @(negedge CORE_CLK);
    repeat (3000)
    begin
      GLOBAL_CACHE_DISABLE_FLAG = $urandom % 8 == 0;
      NOT_WRITE_THROUGH_FLAG = 1'($urandom);
      EXT_CACHE_DISABLE = $urandom % 8 == 0;
      EXT_FORCE_WT = $urandom % 8 == 0;
      RANGE_HIT = $urandom % 4 == 0;
      RANGE_MEM_TYPE = mt[$urandom % 5];
      PAGE_FLAGS = cpps_page_t'($urandom % 3 == 0 ? 6'($urandom) : 6'h00);
      LINE_WT_SELECT = $urandom % 8 == 0;
      MISC_FEATURE_ENABLE = (8'($urandom) & 8'hbf) | {1'b0, l3d, 6'h00};
      ACC_IS_FETCH = 1'($urandom);
      ACC_MISS = 1'($urandom);
      @(negedge CORE_CLK);
    end
    $display("test l3d=%0b stall=%0b done, %0d checks", l3d, slow, check_count);
  endtask
  initial
  begin
    void'($urandom(32'hd2dc));
    repeat (8) @(negedge CORE_CLK);
    RESET = 1'b0;
    run(1'b0, 1'b0);
    run(1'b1, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
